// ---- firx_regs.vh ----
// firx_regs.vh: constants for the fir filter engine
// assumes inclusion by the engine and its fifo only
`ifndef FIRX_REGS_VH
`define FIRX_REGS_VH
`define FIRX_NUM_TAPS      16
`define FIRX_DATA_W        16
`define FIRX_COEF_W        16
`define FIRX_MAC_CYCLES    4
`define FIRX_MAX_RATE      1024
`define FIRX_MAX_RATE_MC   512
`define FIRX_MAX_SETS      256
`define FIRX_CFG_W         8
`define FIRX_CFG_SET_LSB   0
`define FIRX_CFG_SET_W     8
`define FIRX_FIFO_DEPTH    32
`define FIRX_CLR_MIN_CYC   2
`define FIRX_MODE_SINGLE   2'h0
`define FIRX_MODE_DECIM    2'h1
`define FIRX_MODE_INTERP   2'h2
`endif

// ---- firx_fifo.v ----
// firx_fifo.v: holds no logic of its own
// assumes the buffer module firx_fifo is built with the engine in firx_engine.v

// ---- firx_engine.v ----
// firx_engine.v: time-shared mac fir filter with rate change and config stream
// assumes stream partners keep valid/ready rules; one clock, sync inputs
//
// Overview of operation
// - each output is sum of coefficient n times input n samples back
// - accumulator wide enough that sums of products never overflow
// - one time-shared mac serves all taps, fewest multipliers for throughput
// - mac cycles per sample fixed: one cycle per tap, NTAPS of them in a sample period of NTAPS+3 cycles outside interpolation
// - one to 256 coefficient sets, each up to the tap count
// - coefficient and data widths configurable, two to 49 bits
// - one to sixteen parallel paths sharing one control
// - systolic form supports 1 to 256 channels plus 512 and 1024
// - transpose form: one channel, no symmetry, no fractional or super rate
// - rate factor up to 1024 single channel, 512 with multiple channels
// - fractional and advanced-sequence rate filters skip coefficient symmetry
// - above clock rate: no fractional, hilbert or half-band optimisation
// - state updates on rising edge only while clock enable high or clear asserted
// - active-low clear is synchronous, beats enable, held two cycles
// - config ready high when a config word can be taken
// - words move only when valid and ready both high
// - enable low freezes all state and outputs while clear is not asserted
// - input ready always present; output ready is a build option
// - event pulses for missing or unexpected config last
`timescale 1ns/10ps
`include "firx_regs.vh"
module firx_engine #(
	parameter NTAPS     = `FIRX_NUM_TAPS,
	parameter DW        = `FIRX_DATA_W,
	parameter CW        = `FIRX_COEF_W,
	parameter NPATH     = 1,
	parameter NSETS     = 4,
	parameter MODE      = `FIRX_MODE_SINGLE,
	parameter RATE      = 2,
	parameter USE_OREADY = 1,
	parameter CFG_WORDS = 1
) (
	input  wire                   clk,
	input  wire                   sys_rst,
	input  wire                   clk_en,
	input  wire                   clr_n,
	input  wire                   cfg_valid,
	output reg                    cfg_ready,
	input  wire [`FIRX_CFG_W-1:0] cfg_data,
	input  wire                   cfg_last,
	input  wire                   coef_we,
	input  wire [7:0]             coef_set,
	input  wire [7:0]             coef_idx,
	input  wire [CW-1:0]          coef_val,
	input  wire                   in_valid,
	output reg                    in_ready,
	input  wire [NPATH*DW-1:0]    in_data,
	output reg                    out_valid,
	input  wire                   out_ready,
	output reg  [NPATH*(DW+CW+$clog2(NTAPS))-1:0] out_data,
	output reg                    ev_cfg_last_missing,
	output reg                    ev_cfg_last_unexpected
);
	// ------------------------------------------------------------
	// sizing
	// ------------------------------------------------------------
	function integer clog2;
		input integer v;
		integer k;
		begin
			k = 0;
			while ((1 << k) < v)
				k = k + 1;
			clog2 = (k < 1) ? 1 : k;
		end
	endfunction

	// port width repeats this sum: localparams are not visible in the port list
	localparam AW_O = DW + CW + $clog2(NTAPS);
	localparam TW   = clog2(NTAPS);
	localparam SW   = (NSETS > 1) ? clog2(NSETS) : 1;
	localparam ST_IDLE = 2'h0;
	localparam ST_MAC  = 2'h1;
	localparam ST_PUSH = 2'h2;

	function [AW_O-1:0] sext_prod;
		input [DW-1:0] x;
		input [CW-1:0] c;
		reg signed [DW+CW-1:0] p;
		begin
			p = $signed(x) * $signed(c);
			sext_prod = {{(AW_O-DW-CW){p[DW+CW-1]}}, p};
		end
	endfunction

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	reg  [CW-1:0]       coef   [0:NSETS*NTAPS-1];
	reg  [NPATH*DW-1:0] dline  [0:NTAPS-1];
	reg  [AW_O-1:0]     acc    [0:NPATH-1];
	reg  [1:0]          state;
	reg  [TW-1:0]       tap;
	reg  [10:0]         phase;
	reg  [10:0]         rep;
	reg  [SW-1:0]       act_set;
	reg  [7:0]          cfg_cnt;
	reg                 clr_q;
	wire                ce;
	wire                clr;
	wire                f_in_ready;
	wire                f_out_valid;
	wire [NPATH*AW_O-1:0] f_out_data;
	wire                sink_ready;
	reg  [NPATH*AW_O-1:0] res;
	reg                 res_valid;
	integer             i;
	integer             p;

	// clear overrides enable; the two-cycle minimum is the master's duty
	assign clr = ~clr_n;
	assign ce  = clk_en | clr;
	// without output ready the sink is taken as always ready
	assign sink_ready = (USE_OREADY != 0) ? out_ready : 1'b1;

	// ------------------------------------------------------------
	// coefficient store (reload side, no clear: coefficients survive reset)
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (clk_en & coef_we & (coef_idx < NTAPS) & (coef_set < NSETS))
			coef[coef_set*NTAPS + coef_idx] <= coef_val;
	end

	// ------------------------------------------------------------
	// config channel
	// ------------------------------------------------------------
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_ready              <= 1'b0;
			cfg_cnt                <= 8'h00;
			act_set                <= {SW{1'b0}};
			ev_cfg_last_missing    <= 1'b0;
			ev_cfg_last_unexpected <= 1'b0;
			clr_q                  <= 1'b0;
		end else if (clr) begin
			cfg_ready              <= 1'b0;
			cfg_cnt                <= 8'h00;
			ev_cfg_last_missing    <= 1'b0;
			ev_cfg_last_unexpected <= 1'b0;
			clr_q                  <= 1'b1;
		end else if (ce) begin
			clr_q                  <= 1'b0;
			cfg_ready              <= 1'b1;
			ev_cfg_last_missing    <= 1'b0;
			ev_cfg_last_unexpected <= 1'b0;
			if (cfg_valid & cfg_ready) begin
				act_set <= cfg_data[`FIRX_CFG_SET_LSB +: SW];
				// the packet length is fixed; last is checked against it
				if (cfg_cnt == CFG_WORDS[7:0] - 8'h01) begin
					cfg_cnt             <= 8'h00;
					ev_cfg_last_missing <= ~cfg_last;
				end else begin
					cfg_cnt                <= cfg_cnt + 8'h01;
					ev_cfg_last_unexpected <= cfg_last;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// mac sequencer: one multiplier per path, one tap per cycle
	// ------------------------------------------------------------
	// full rate would need NTAPS macs; this build trades throughput for area
	// single channel, plain tap sum: no symmetry or fractional forms
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state     <= ST_IDLE;
			tap       <= {TW{1'b0}};
			phase     <= 11'h000;
			rep       <= 11'h000;
			in_ready  <= 1'b0;
			res_valid <= 1'b0;
			res       <= {(NPATH*AW_O){1'b0}};
			for (p = 0; p < NPATH; p = p + 1)
				acc[p] <= {AW_O{1'b0}};
		end else if (clr) begin
			state     <= ST_IDLE;
			tap       <= {TW{1'b0}};
			phase     <= 11'h000;
			rep       <= 11'h000;
			in_ready  <= 1'b0;
			res_valid <= 1'b0;
		end else if (ce) begin
			case (state)
			ST_IDLE: begin
				res_valid <= 1'b0;
				in_ready  <= ~clr_q;
				if (in_valid & in_ready) begin
					in_ready <= 1'b0;
					for (i = NTAPS-1; i > 0; i = i - 1)
						dline[i] <= dline[i-1];
					dline[0] <= in_data;
					tap      <= {TW{1'b0}};
					for (p = 0; p < NPATH; p = p + 1)
						acc[p] <= {AW_O{1'b0}};
					state    <= ST_MAC;
				end
			end
			ST_MAC: begin
				// sum of coef[n] * x[k-n], one tap a cycle
				for (p = 0; p < NPATH; p = p + 1)
					acc[p] <= acc[p] + sext_prod(dline[tap][p*DW +: DW],
						coef[act_set*NTAPS + tap]);
				if (tap == NTAPS[TW-1:0] - 1'b1) begin
					state <= ST_PUSH;
					rep   <= 11'h000;
				end else begin
					tap <= tap + 1'b1;
				end
			end
			ST_PUSH: begin
				for (p = 0; p < NPATH; p = p + 1)
					res[p*AW_O +: AW_O] <= acc[p];
				res_valid <= 1'b0;
				if (MODE == `FIRX_MODE_DECIM) begin
					res_valid <= (phase == RATE[10:0] - 11'h001);
					phase     <= (phase == RATE[10:0] - 11'h001) ? 11'h000
						: phase + 11'h001;
					state     <= ST_IDLE;
				end else if (MODE == `FIRX_MODE_INTERP) begin
					// zero-order hold: push the same result RATE times
					if (f_in_ready & ~res_valid) begin
						res_valid <= 1'b1;
						rep       <= rep + 11'h001;
					end
					if (rep == RATE[10:0] - 11'h001 && f_in_ready && ~res_valid)
						state <= ST_IDLE;
				end else begin
					res_valid <= 1'b1;
					state     <= ST_IDLE;
				end
				// hold if the fifo is full: back-pressure to the source
				if (~f_in_ready) begin
					res_valid <= 1'b0;
					state     <= ST_PUSH;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// output buffer and registered output stage
	// ------------------------------------------------------------
	firx_fifo #(
		.WIDTH (NPATH*AW_O),
		.DEPTH (`FIRX_FIFO_DEPTH),
		.AW    (5)
	) u_fifo (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.ce        (ce),
		.clr       (clr),
		.in_valid  (res_valid),
		.in_ready  (f_in_ready),
		.in_data   (res),
		.out_valid (f_out_valid),
		.out_ready (~out_valid | sink_ready),
		.out_data  (f_out_data)
	);

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_valid <= 1'b0;
			out_data  <= {(NPATH*AW_O){1'b0}};
		end else if (clr) begin
			out_valid <= 1'b0;
		end else if (ce) begin
			if (~out_valid | sink_ready) begin
				out_valid <= f_out_valid;
				if (f_out_valid)
					out_data <= f_out_data;
			end
		end
	end
endmodule

// ------------------------------------------------------------
// output fifo, valid/ready on both sides
// ------------------------------------------------------------
module firx_fifo #(
	parameter WIDTH = 40,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             clk,
	input  wire             sys_rst,
	input  wire             ce,
	input  wire             clr,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	// one bit wider than the pointers so full and empty differ
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	// read is combinational; the engine's output stage registers it
	assign out_data  = mem[rd_ptr];
	assign push      = ce & in_valid & in_ready;
	assign pop       = ce & out_valid & out_ready;

	always @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else if (clr) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else if (ce) begin
			if (push)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (push & ~pop)
				count <= count + 1'b1;
			else if (pop & ~push)
				count <= count - 1'b1;
		end
	end
endmodule

// ---- firx_engine_props.sv ----
// firx_engine_props.sv: assertion checker on engine ports
// assumes default build, 36-bit out_data, one clock
`timescale 1ns/10ps
module firx_chk (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        clk_en,
	input wire logic        clr_n,
	input wire logic        cfg_valid,
	input wire logic        cfg_ready,
	input wire logic        cfg_last,
	input wire logic        in_valid,
	input wire logic        in_ready,
	input wire logic        out_valid,
	input wire logic        out_ready,
	input wire logic [35:0] out_data,
	input wire logic        ev_cfg_last_missing,
	input wire logic        ev_cfg_last_unexpected
);
	wire tk = in_valid & in_ready & clk_en & clr_n;
	wire ctk = cfg_valid & cfg_ready & clk_en & clr_n;
	wire hold = out_valid & !out_ready & clk_en & clr_n;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ----
	// properties
	// ----
	sequence s_cfg; ctk; endsequence
	sequence s_busy; !in_ready [*8]; endsequence
	clr_hold_a: assert property (!clr_n |=> !cfg_ready && !in_ready && !out_valid)
		else $error("ready seen in clear");
	// a clear ends the busy spell early, so it also ends the attempt
	take_busy_a: assert property (disable iff (sys_rst || !clr_n) tk |=> s_busy)
		else $error("input ready too soon");
	out_hold_a: assert property (hold |=> out_valid && $stable(out_data))
		else $error("output dropped untaken");
	state_freeze_a: assert property (!clk_en && clr_n |=> $stable({in_ready, cfg_ready, out_valid}))
		else $error("state moved while disabled");
	cfg_up_a: assert property (clr_n && clk_en && $past(clr_n) && !$past(sys_rst) |=> cfg_ready)
		else $error("config ready low");
	miss_ev_a: assert property (s_cfg ##0 !cfg_last |=> ev_cfg_last_missing)
		else $error("missing last not flagged");
	ok_ev_a: assert property (s_cfg ##0 cfg_last |=> !ev_cfg_last_missing && !ev_cfg_last_unexpected)
		else $error("event on good packet");
	ev_src_a: assert property ($rose(ev_cfg_last_missing) |-> $past(ctk))
		else $error("event without config take");
endmodule
bind firx_engine firx_chk i_chk (.clk, .sys_rst, .clk_en, .clr_n, .cfg_valid, .cfg_ready,
	.cfg_last, .in_valid, .in_ready, .out_valid, .out_ready, .out_data,
	.ev_cfg_last_missing, .ev_cfg_last_unexpected);

// ---- firx_sink.sv ----
// firx_sink.sv: downstream slave model, stall set by the bench
// assumes 36-bit words; ready moves only after a rising edge
`timescale 1ns/10ps
module firx_sink (
	input  wire logic        clk,
	input  wire logic        clk_en,
	input  wire logic        stall,
	input  wire logic        out_valid,
	output logic             out_ready,
	input  wire logic [35:0] out_data
);
	logic [35:0] got [0:127];
	int          n_got = 0;
	initial out_ready = 1'b0;
	// nba keeps the engine sampling the old ready
	always @(posedge clk) begin
		out_ready <= !stall;
		if (out_valid && out_ready && clk_en) begin
			got[n_got] <= out_data;
			n_got <= n_got + 1;
		end
	end
endmodule

// ---- firx_engine_tb_top.sv ----
// firx_engine_tb_top.sv: self-checking bench for the filter engine
// assumes default build: 16 taps, 16-bit data and coefs, one lane
`timescale 1ns/10ps
module firx_engine_tb_top;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        clk_en = 1'b1;
	logic        clr_n = 1'b1;
	logic        cfg_valid = 1'b0;
	logic        cfg_last = 1'b0;
	logic [7:0]  cfg_data = 8'h00;
	logic        coef_we = 1'b0;
	logic [7:0]  coef_set = 8'h00;
	logic [7:0]  coef_idx = 8'h00;
	logic [15:0] coef_val = 16'h0000;
	logic        in_valid = 1'b0;
	logic [15:0] in_data = 16'h0000;
	logic        stall = 1'b0;
	wire         cfg_ready, in_ready, out_valid, out_ready;
	wire  [35:0] out_data;
	wire         ev_cfg_last_missing, ev_cfg_last_unexpected;
	int          err_total = 0;
	int          samples_checked = 0;
	firx_engine i_firx_engine (.clk, .sys_rst, .clk_en, .clr_n, .cfg_valid, .cfg_ready,
		.cfg_data, .cfg_last, .coef_we, .coef_set, .coef_idx, .coef_val, .in_valid,
		.in_ready, .in_data, .out_valid, .out_ready, .out_data, .ev_cfg_last_missing,
		.ev_cfg_last_unexpected);
	firx_sink i_firx_sink (.clk, .clk_en, .stall, .out_valid, .out_ready, .out_data);
	always #5 clk = ~clk;
	task automatic print_verdict;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cfg(input logic [7:0] d, input logic l);
		@(negedge clk) {cfg_valid, cfg_data, cfg_last} = {1'b1, d, l};
		do @(posedge clk); while (!cfg_ready);
		@(negedge clk) cfg_valid = 1'b0;
		chk(ev_cfg_last_missing, !l);
	endtask
	// in_valid stays up on refusal: a word is never withdrawn
	task automatic put(input logic [15:0] x, output bit ok);
		@(negedge clk) {in_valid, in_data} = {1'b1, x};
		ok = 0;
		repeat (60) if (!ok) begin
			@(posedge clk);
			ok = in_ready && clk_en;
		end
		if (ok) @(negedge clk) in_valid = 1'b0;
	endtask
	task automatic send(input logic [15:0] x);
		bit ok;
		put(x, ok);
		chk(ok, 1);
	endtask
	task automatic drain(input int n);
		repeat (400) if (i_firx_sink.n_got < n) @(negedge clk);
		chk(i_firx_sink.n_got, n);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_impulse;
		for (int n = 0; n < 32; n++) begin
			@(negedge clk) {coef_we, coef_set, coef_idx} = {1'b1, 8'(n / 16), 8'(n % 16)};
			coef_val = (n < 16) ? 16'(n + 1) : 16'h8000;
		end
		@(negedge clk) coef_we = 1'b0;
		chk(cfg_ready, 1);
		chk(in_ready, 1);
		cfg(8'h00, 1'b0);
		cfg(8'h00, 1'b1);
		for (int k = 0; k < 32; k++) send((k == 16) ? 16'h0003 : 16'h0000);
		drain(32);
		for (int k = 0; k < 16; k++) chk(i_firx_sink.got[16 + k], 36'(3 * (k + 1)));
	endtask
	task automatic t_wide;
		cfg(8'h01, 1'b1);
		for (int k = 0; k < 16; k++) send(16'h8000);
		drain(48);
		for (int k = 0; k < 16; k++) chk(i_firx_sink.got[32 + k], 36'(k + 1) << 30);
	endtask
	// refusal point allows for buffer depth plus pipeline slack
	task automatic t_fill;
		bit ok;
		int took;
		took = 0;
		@(negedge clk) stall = 1'b1;
		do begin put(16'h0001, ok); took += ok; end while (ok && took < 40);
		chk(took >= 32 && took < 40, 1);
		@(negedge clk) stall = 1'b0;
		while (took < 40) begin put(16'h0001, ok); took += ok; end
		drain(88);
		chk(i_firx_sink.got[87], 36'hf_fff8_0000);
	endtask
	task automatic t_freeze;
		send(16'h0001);
		@(negedge clk) clk_en = 1'b0;
		repeat (30) @(negedge clk);
		chk(in_ready, 0);
		chk(i_firx_sink.n_got, 88);
		clk_en = 1'b1;
		drain(89);
		chk(i_firx_sink.got[88], 36'hf_fff8_0000);
	endtask
	task automatic t_clear;
		send(16'h0000);
		@(negedge clk) clr_n = 1'b0;
		@(negedge clk) chk(cfg_ready, 0);
		@(negedge clk) clr_n = 1'b1;
		repeat (3) @(negedge clk);
		chk(cfg_ready, 1);
		chk(in_ready, 1);
	endtask
	initial begin
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge clk);
		t_impulse;
		t_wide;
		t_fill;
		t_freeze;
		t_clear;
		print_verdict;
	end
	initial begin
		#200000;
		err_total++;
		print_verdict;
	end
endmodule
